/* logic/adsf_defs.svh */
// Constants for the actuator driver serial frame control block.
`ifndef ADSF_DEFS_SVH
`define ADSF_DEFS_SVH
`define ADSF_CLK_MHZ          100
`define ADSF_STARTUP_TYP_US   80
`define ADSF_STARTUP_MAX_US   300
`define ADSF_STARTUP_CYC      (`ADSF_STARTUP_TYP_US * `ADSF_CLK_MHZ)
`define ADSF_STARTUP_MAX_CYC  (`ADSF_STARTUP_MAX_US * `ADSF_CLK_MHZ)
`define ADSF_EN_GAP_US        50
`define ADSF_EN_GAP_CYC       (`ADSF_EN_GAP_US * `ADSF_CLK_MHZ)
`define ADSF_IFG_US           4
`define ADSF_IFG_CYC          (`ADSF_IFG_US * `ADSF_CLK_MHZ)
`define ADSF_FRAME_BITS       16
`define ADSF_FAULT_BIT        0
// Synchroniser reset in the order enable, select, clock, data: the pin idle levels.
`define ADSF_SYNC_RST         4'h4
`endif

/* logic/adsf_pkg.sv */
// Types shared by the actuator driver serial frame control block.
`default_nettype none
package adsf_pkg;
   typedef struct packed {
      logic sel_n;
      logic sclk;
      logic sdi;
   } adsf_pins_s;
   typedef struct packed {
      logic dat;
      logic oe;
   } adsf_sdo_s;
endpackage : adsf_pkg
`default_nettype wire

/* logic/adsf_frame_ctrl.sv */
// Serial frame control: startup flag, frame shifting and output transfer.
// Functional notes
// - Startup flag clears within startup time
// - Select falling enables serial output driver
// - Input sampled on rising serial clock
// - Output changes only on falling clock, apart from the fault bit at select fall and the clear while enable is low
// - Select rising copies frame to outputs
// - Fault bit driven at select fall
// - Fault bit holds while no clock edges
// - Clockless frame updates nothing
// - Enable low clears everything, outputs released
// - Output high impedance while select high
`timescale 1ns/1ns
`default_nettype none
`include "adsf_defs.svh"
module adsf_frame_ctrl
   import adsf_pkg::*;
#(
   parameter int WIDTH       = `ADSF_FRAME_BITS,
   parameter int STARTUP_CYC = `ADSF_STARTUP_CYC
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   input  wire logic             i_ce,
   input  wire logic             i_enable,
   input  wire adsf_pins_s       i_pins,
   input  wire logic [WIDTH-1:0] i_status,
   output logic                  o_startup_pending,
   output adsf_sdo_s             o_sdo,
   output logic [WIDTH-1:0]      o_switch_ctrl,
   output logic                  o_frame_done
);
   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks. The shift engine needs at least two bits, and a startup
   // count beyond the worst case would break the startup promise.
   if (WIDTH < 2 || WIDTH > 64) begin : g_bad_width
      $error("WIDTH out of range");
   end
   if (STARTUP_CYC < 1 || STARTUP_CYC > `ADSF_STARTUP_MAX_CYC) begin : g_bad_startup
      $error("STARTUP_CYC out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only the second stage is read by logic.
   // Reset loads the pin idle levels (enable low, select high), so that no false
   // enable pulse or select edge follows the release of reset.
   logic [3:0] meta_r;
   logic [3:0] sync_r;
   logic       sclk_d_r;
   logic       sel_d_r;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r   <= `ADSF_SYNC_RST;
         sync_r   <= `ADSF_SYNC_RST;
         sclk_d_r <= 1'b0;
         sel_d_r  <= 1'b1;
      end else if (i_ce) begin
         meta_r   <= {i_enable, i_pins.sel_n, i_pins.sclk, i_pins.sdi};
         sync_r   <= meta_r;
         sclk_d_r <= sync_r[1];
         // Delay the gated select, so that standby cannot hide a select edge.
         sel_d_r  <= sync_r[2] | ~sync_r[3];
      end
   end

   // Every pin event is seen three clocks after the pin moves, so each phase of
   // the link clock must last at least three system clocks. Select counts as
   // released while in standby, which keeps the link idle there.
   wire en_s    = sync_r[3];
   wire sel_n_s = sync_r[2] | ~en_s;
   wire sclk_s  = sync_r[1];
   wire sdi_s   = sync_r[0];
   wire rise    = sclk_s & ~sclk_d_r & ~sel_n_s;
   wire fall    = ~sclk_s & sclk_d_r & ~sel_n_s;
   wire sel_fall = ~sel_n_s & sel_d_r;
   wire sel_rise = sel_n_s & ~sel_d_r & en_s;

   ////////////////////////////////////////////////////////////////////////////
   // Startup timer after enable rises.
   localparam int CW = $clog2(STARTUP_CYC + 1);
   logic [CW-1:0] start_cnt_r;
   logic          en_d_r;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_cnt_r       <= '0;
         en_d_r            <= 1'b0;
         o_startup_pending <= 1'b1;
      end else if (i_ce) begin
         en_d_r <= en_s;
         if (!en_s) begin
            start_cnt_r       <= '0;
            o_startup_pending <= 1'b1;
         end else if (o_startup_pending) begin
            start_cnt_r <= start_cnt_r + 1'b1;
            if (start_cnt_r == CW'(STARTUP_CYC - 1)) o_startup_pending <= 1'b0;
         end
      end
   end

   // The count stops at the typical startup time; the elaboration check keeps it
   // at or below the worst case as well.
   a_pend_at_enable: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && en_s && !en_d_r |-> o_startup_pending)
      else $error("startup flag low as enable rises");
   a_startup_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && o_startup_pending |-> start_cnt_r <= CW'(STARTUP_CYC - 1))
      else $error("startup count ran past its end");
   a_startup_end: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && $fell(o_startup_pending) |-> $past(start_cnt_r) == CW'(STARTUP_CYC - 1))
      else $error("startup flag cleared at wrong count");

   ////////////////////////////////////////////////////////////////////////////
   // Shift engine. Status is loaded at select fall so bit 0 appears first.
   logic [WIDTH-1:0] rx_r;
   logic [WIDTH-1:0] tx_r;
   logic             got_rise_r;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_r          <= '0;
         tx_r          <= '0;
         got_rise_r    <= 1'b0;
         o_sdo         <= '0;
         o_switch_ctrl <= '0;
         o_frame_done  <= 1'b0;
      end else if (i_ce) begin
         o_frame_done <= 1'b0;
         if (!en_s) begin
            rx_r          <= '0;
            tx_r          <= '0;
            got_rise_r    <= 1'b0;
            o_sdo         <= '0;
            o_switch_ctrl <= '0;
         end else begin
            if (sel_fall) begin
               tx_r       <= i_status >> 1;
               got_rise_r <= 1'b0;
               o_sdo.oe   <= 1'b1;
               o_sdo.dat  <= i_status[`ADSF_FAULT_BIT];
            end else if (sel_n_s) begin
               o_sdo.oe <= 1'b0;
            end
            if (rise) begin
               rx_r       <= {rx_r[WIDTH-2:0], sdi_s};
               got_rise_r <= 1'b1;
            end
            // Between falling edges the output bit is left alone, so the fault bit
            // stands for as long as the master keeps the clock still.
            if (fall) begin
               o_sdo.dat <= tx_r[0];
               tx_r      <= tx_r >> 1;
            end
            // A frame without a single rising edge transfers nothing, so a bare
            // select pulse may be used to poll the fault bit.
            if (sel_rise && got_rise_r) begin
               o_switch_ctrl <= rx_r;
               o_frame_done  <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_oe_off_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && $past(i_ce) && $past(sel_n_s) && !sel_fall |-> !o_sdo.oe)
      else $error("serial output driven while deselected");
   a_oe_on_select: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && sel_fall |=> o_sdo.oe)
      else $error("serial output not enabled at select fall");
   a_fault_first: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && sel_fall |=> o_sdo.dat == $past(i_status[0]))
      else $error("fault bit not presented at select fall");
   a_dat_on_fall: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && $past(i_ce) && $changed(o_sdo.dat) && !$past(sel_fall) && en_s && $past(en_s)
      |-> $past(fall))
      else $error("serial output changed off a falling edge");
   a_fault_holds: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && $past(i_ce) && !sel_n_s && !$past(fall) && !$past(sel_fall) && $past(en_s)
      |-> $stable(o_sdo.dat))
      else $error("fault bit lost without clock edge");
   a_no_update: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && sel_rise && !got_rise_r && en_s |=> $stable(o_switch_ctrl))
      else $error("clockless frame updated outputs");
   a_transfer: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && sel_rise && got_rise_r |=> o_switch_ctrl == $past(rx_r) && o_frame_done)
      else $error("frame not transferred at select rise");
   a_rx_sample: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && rise && en_s |=> rx_r[0] == $past(sdi_s))
      else $error("input not sampled on rising edge");
   a_standby_clr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && !en_s |=> o_switch_ctrl == '0 && !o_sdo.oe && o_startup_pending)
      else $error("standby did not clear state");
   ////////////////////////////////////////////////////////////////////////////
   // Shifting, output enable, transfer and standby clearing.
   a_got_rise_clr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && sel_fall && !rise |=> !got_rise_r)
      else $error("rising edge mark kept across select fall");
   a_oe_while_sel: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && o_sdo.oe && !sel_n_s |=> o_sdo.oe)
      else $error("serial output released while selected");
   a_done_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && o_frame_done |=> !o_frame_done)
      else $error("frame done longer than one cycle");
   a_done_gated: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && o_frame_done |-> $past(got_rise_r))
      else $error("frame done without a rising edge");
   a_tx_shift: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && fall && !sel_fall |=> o_sdo.dat == $past(tx_r[0]))
      else $error("wrong status bit shifted out");
   a_rx_shift: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && rise |=> rx_r[WIDTH-1:1] == $past(rx_r[WIDTH-2:0]))
      else $error("input register did not shift");
   a_rx_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && sel_n_s && en_s |=> $stable(rx_r))
      else $error("input register moved while deselected");
   a_switch_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && en_s && !(sel_rise && got_rise_r) |=> $stable(o_switch_ctrl))
      else $error("switch controls moved without transfer");
   a_standby_rx: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && !en_s |=> rx_r == '0 && !got_rise_r)
      else $error("standby did not clear input register");
endmodule : adsf_frame_ctrl
`default_nettype wire

/* testbench/adsf_mstr_model.sv */
// Serial bus master model that drives the frame control pins.
`timescale 1ns/1ns
`default_nettype none
module adsf_mstr_model
   import adsf_pkg::*;
(
   input  wire logic      i_mclk,
   input  wire adsf_sdo_s i_sdo,
   output var adsf_pins_s o_pins
);
   // Idle levels follow the pin pulls: select high, clock and data low.
   initial o_pins = 3'h4;
   ////////////////////////////////////////////////////////////////////////////
   task automatic hp();
      repeat (4) @(posedge i_mclk);
   endtask : hp
   task automatic select(input logic on);
      @(posedge i_mclk);
      o_pins.sel_n <= ~on;
   endtask : select
   // Data is set up a half period ahead of each rising clock edge.
   task automatic xfer(input logic [15:0] d, output logic [15:0] q);
      select(1'b1);
      for (int i = 0; i < 16; i++) begin
         o_pins.sdi <= d[15 - i];
         hp();
         // An undriven output line reads as the inverse of the last value.
         q[i] = i_sdo.oe ? i_sdo.dat : ~i_sdo.dat;
         o_pins.sclk <= 1'b1;
         hp();
         o_pins.sclk <= 1'b0;
      end
      hp();
      o_pins.sel_n <= 1'b1;
      o_pins.sdi   <= 1'b0;
   endtask : xfer
endmodule : adsf_mstr_model
`default_nettype wire

/* testbench/adsf_frame_ctrl_test.sv */
// Self-checking bench for the serial frame control block.
`timescale 1ns/1ns
`default_nettype none
module adsf_frame_ctrl_test;
   import adsf_pkg::*;
   logic        mclk  = 1'b0;
   logic        rst_n = 1'b0;
   logic        en    = 1'b0;
   logic        ce    = 1'b1;
   logic [15:0] st    = 16'h0000;
   adsf_pins_s  pins;
   adsf_sdo_s   sdo;
   logic [15:0] sw;
   logic        pend;
   logic        done;
   int          failures   = 0;
   int          num_checks = 0;
   int          dones      = 0;
   localparam int START_CYC = 20;
   initial forever #5 mclk = ~mclk;
   always @(posedge mclk) if (done === 1'b1) dones++;
   adsf_frame_ctrl #(.WIDTH(16), .STARTUP_CYC(START_CYC)) dut_u (.i_mclk(mclk), .i_rst_n(rst_n),
      .i_ce(ce), .i_enable(en), .i_pins(pins), .i_status(st), .o_startup_pending(pend),
      .o_sdo(sdo), .o_switch_ctrl(sw), .o_frame_done(done));
   adsf_mstr_model mdl_u (.i_mclk(mclk), .i_sdo(sdo), .o_pins(pins));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   task automatic await(input bit is_done, input int lim, output int n);
      for (n = 0; n < lim; n++) begin
         @(posedge mclk);
         #1;
         if (is_done ? done === 1'b1 : pend === 1'b0) return;
      end
      failures++;
      close_out();
   endtask : await
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_start();
      int n;
      #1 chk({15'h0, pend}, 16'h0001);
      chk({15'h0, sdo.oe}, 16'h0000);
      @(posedge mclk);
      en <= 1'b1;
      await(1'b0, 75, n);
      chk({15'h0, n >= START_CYC && n <= START_CYC + 3}, 16'h0001);
      repeat (5000) @(posedge mclk);
   endtask : t_start
   task automatic t_frame(input logic [15:0] d);
      logic [15:0] q;
      int          n;
      mdl_u.xfer(d, q);
      chk(q, st);
      await(1'b1, 10, n);
      chk(sw, d);
      chk({15'h0, sdo.oe}, 16'h0000);
      repeat (400) @(posedge mclk);
   endtask : t_frame
   task automatic t_idle();
      logic [15:0] prev;
      int          d0;
      prev = sw;
      d0   = dones;
      mdl_u.select(1'b1);
      repeat (6) @(posedge mclk);
      #1 chk({sdo.oe, sdo.dat}, {1'b1, st[0]});
      repeat (200) @(posedge mclk);
      #1 chk({sdo.oe, sdo.dat}, {1'b1, st[0]});
      mdl_u.select(1'b0);
      repeat (10) @(posedge mclk);
      chk(sw, prev);
      chk(dones[15:0], d0[15:0]);
      repeat (400) @(posedge mclk);
   endtask : t_idle
   task automatic t_standby();
      ce <= 1'b0;
      en <= 1'b0;
      repeat (10) @(posedge mclk);
      #1 chk({sw[14:0], pend}, 16'hFFFE);
      @(posedge mclk);
      ce <= 1'b1;
      repeat (10) @(posedge mclk);
      #1 chk({sw[14:0], pend}, 16'h0001);
      chk({15'h0, sdo.oe}, 16'h0000);
   endtask : t_standby
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_start();
      st <= 16'hA5C3;
      t_frame(16'h3C5A);
      st <= 16'h0F0E;
      t_frame(16'hFFFF);
      st <= 16'h8001;
      t_idle();
      t_standby();
      close_out();
   end
endmodule : adsf_frame_ctrl_test
`default_nettype wire
